// ### src/adcdc_defs.svh
// Purpose: shared constants of the converter diagnostic/control bank
// Assumes: included by its bare name from the design, the assertions and the bench
// Notes: definitions only
`ifndef ADCDC_DEFS_SVH
`define ADCDC_DEFS_SVH
// ************************************
// register addresses (6-bit comms field)
// ************************************
`define ADCDC_A_STATUS 6'h00
`define ADCDC_A_CTRL 6'h01
`define ADCDC_A_ID 6'h05
`define ADCDC_A_FLAGS 6'h06
`define ADCDC_A_FEN 6'h07
`define ADCDC_A_TALLY 6'h08
`define ADCDC_A_CHAN0 6'h09
`define ADCDC_A_CHAN15 6'h18
`define ADCDC_A_OFF0 6'h21
`define ADCDC_A_OFF7 6'h28
`define ADCDC_A_GAIN0 6'h29
`define ADCDC_A_GAIN7 6'h30
// ************************************
// reset values
// ************************************
`define ADCDC_CTRL_RST 16'h0000
`define ADCDC_FLAGS_RST 24'h00_0000
`define ADCDC_FEN_RST 24'h00_0040
`define ADCDC_TALLY_RST 8'h00
`define ADCDC_OFF_RST 24'h80_0000
`define ADCDC_GAIN_RST 24'h50_0000
`define ADCDC_CHAN0_RST 16'h8001
`define ADCDC_CHANX_RST 16'h0001
// ************************************
// field positions
// ************************************
`define ADCDC_FB_MAP 1
`define ADCDC_FB_WRITE 3
`define ADCDC_FB_READ 4
`define ADCDC_FB_SCLK 5
`define ADCDC_FB_IGNORE 6
`define ADCDC_FB_IMPL 24'h0F_FAFF
`define ADCDC_EN_TALLY 22
`define ADCDC_ST_ERR 6
`define ADCDC_CMD_WEN 7
`define ADCDC_CMD_RD 6
`define ADCDC_CH_EN 15
`define ADCDC_CH_SETUP 14:12
`define ADCDC_CH_AINP 9:5
`define ADCDC_CH_AINM 4:0
`define ADCDC_C_CLK 1:0
`define ADCDC_C_MODE 5:2
`define ADCDC_C_POWER 7:6
`define ADCDC_C_REFEN 8
`define ADCDC_C_STATUS 10
`define ADCDC_C_CREAD 11
`define ADCDC_C_DELAY 12
// ************************************
// mode codes and frame lengths (sclk edges)
// ************************************
`define ADCDC_MODE_CONT 4'h0
`define ADCDC_MODE_IOFF 4'h5
`define ADCDC_MODE_IGAIN 4'h6
`define ADCDC_MODE_SOFF 4'h7
`define ADCDC_MODE_SGAIN 4'h8
`define ADCDC_CMD_LAST 6'h07
`define ADCDC_TX_LOAD 6'h08
`define ADCDC_CNT_MAX 6'h3F
`define ADCDC_LEN1 6'h10
`define ADCDC_LEN2 6'h18
`define ADCDC_LEN3 6'h20
`endif

// ### src/adcdc_pkg.sv
// Purpose: types of the converter diagnostic/control bank
// Assumes: nothing
// Notes: constants live in adcdc_defs.svh
package adcdc_pkg;
  typedef logic [5:0] adcdc_addr_t; // register address
  typedef logic [23:0] adcdc_word_t; // widest register
  typedef logic [15:0] adcdc_half_t; // channel/control width
endpackage

// ### src/adcdc_regs.sv
// Purpose: diagnostic flags, control and channel sequencing of the converter
// Assumes: serial port mode 3, cs_n high between frames, msb first
// Notes: serial side on sclk_i, everything else on clk_i
//
// What this block does
// - fault enable register, resets to write-block only
// - flag writes made while writing is blocked
// - flag reads/writes of invalid register addresses
// - flag frames with wrong serial clock count
// - one flag bit per source, read-only
// - summary error bit is OR of flags
// - failing check sets its flag and summary
// - 8-bit read-only master clock tally register
// - control register holds the power mode
// - control register selects the operating mode
// - control holds clock source and reference enable
// - control enables status append and continuous readback
// - calibration overwrites the selected setup coefficients
// - channel msb enables that channel
// - sequencer steps ascending, wraps to lowest enabled
// - disabled channels skipped, sixteen channels total
// - channel setup field picks one of eight
`timescale 1ns/100ps
`include "adcdc_defs.svh"
module adcdc_regs #(
  parameter logic [7:0] ID_VALUE = 8'h5A, // arbitrary identity value
  parameter int N_CHAN = 16,
  parameter int N_SETUP = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic write_block_i,
  input wire logic conv_done_i,
  input wire logic cal_done_i,
  input wire logic [23:0] cal_coeff_i,
  input wire logic [23:0] fault_event_i,
  output logic miso_o,
  output logic err_o,
  output logic [1:0] power_mode_o,
  output logic [3:0] op_mode_o,
  output logic [1:0] clk_sel_o,
  output logic ref_en_o,
  output logic append_status_o,
  output logic continuous_readback_o,
  output logic output_ready_delay_o,
  output logic [3:0] active_channel_o,
  output logic [2:0] active_setup_o,
  output logic [4:0] active_ainp_o,
  output logic [4:0] active_ainm_o
);
  // ************************************
  // storage
  // ************************************
  logic [15:0] ctrl, next_ctrl; // converter_control
  logic [23:0] fen, next_fen; // fault_enables
  logic [23:0] flags, next_flags; // fault_flags
  logic [7:0] tally, next_tally; // master_clock_tally
  logic err, next_err; // summary error bit
  adcdc_pkg::adcdc_half_t chan [N_CHAN];
  adcdc_pkg::adcdc_half_t next_chan [N_CHAN];
  adcdc_pkg::adcdc_word_t off [N_SETUP];
  adcdc_pkg::adcdc_word_t next_off [N_SETUP];
  adcdc_pkg::adcdc_word_t gain [N_SETUP];
  adcdc_pkg::adcdc_word_t next_gain [N_SETUP];
  logic [3:0] cur, next_cur; // sequencer position
  logic [15:0] act, next_act; // registered copy of current channel
  // snapshots frozen while a frame is open, read by the serial side
  logic [23:0] snap_flags, next_snap_flags;
  logic [7:0] snap_tally, next_snap_tally;
  logic [7:0] snap_status, next_snap_status;

  // ************************************
  // functions
  // ************************************
  // frame length in sclk edges; unknown addresses count as one byte
  function automatic logic [5:0] frame_len(input logic [5:0] a);
    if (a == `ADCDC_A_CTRL || (a >= `ADCDC_A_CHAN0 && a <= `ADCDC_A_CHAN15))
      frame_len = `ADCDC_LEN2;
    else if (a == `ADCDC_A_FLAGS || a == `ADCDC_A_FEN ||
             (a >= `ADCDC_A_OFF0 && a <= `ADCDC_A_GAIN7))
      frame_len = `ADCDC_LEN3;
    else
      frame_len = `ADCDC_LEN1;
  endfunction

  function automatic logic writable(input logic [5:0] a);
    writable = a == `ADCDC_A_CTRL || a == `ADCDC_A_FEN ||
               (a >= `ADCDC_A_CHAN0 && a <= `ADCDC_A_CHAN15) ||
               (a >= `ADCDC_A_OFF0 && a <= `ADCDC_A_GAIN7);
  endfunction

  function automatic logic readable(input logic [5:0] a);
    readable = writable(a) || a == `ADCDC_A_STATUS || a == `ADCDC_A_ID ||
               a == `ADCDC_A_FLAGS || a == `ADCDC_A_TALLY;
  endfunction

  // next enabled channel above c, else lowest enabled, else c
  function automatic logic [3:0] seq_next(input logic [15:0] en,
                                          input logic [3:0] c);
    logic [3:0] r;
    r = c;
    for (int i = N_CHAN - 1; i >= 1; i--) begin
      if (en[4'(c + 4'(i))]) begin
        r = 4'(c + 4'(i));
      end
    end
    seq_next = r;
  endfunction

  // ************************************
  // serial side (sclk domain)
  // ************************************
  logic [5:0] bit_cnt, next_bit_cnt; // cleared by the frame's own cs
  logic [31:0] rx, next_rx;
  logic [7:0] cmd, next_cmd; // comms byte of the last frame
  logic [5:0] frame_bits; // edges seen in the last frame
  logic frame_tog, next_frame_tog; // flips once per clocked frame
  logic [23:0] tx, next_tx;
  logic [23:0] rd_word; // left-aligned read data
  logic [5:0] rd_addr;

  // read mux; config registers other than off and gain only change between frames, so stable
  always_comb begin
    rd_addr = cmd[5:0];
    rd_word = 24'h00_0000;
    if (rd_addr == `ADCDC_A_STATUS) rd_word = {snap_status, 16'h0000};
    else if (rd_addr == `ADCDC_A_CTRL) rd_word = {ctrl, 8'h00};
    else if (rd_addr == `ADCDC_A_ID) rd_word = {ID_VALUE, 16'h0000};
    else if (rd_addr == `ADCDC_A_FLAGS) rd_word = snap_flags;
    else if (rd_addr == `ADCDC_A_FEN) rd_word = fen;
    else if (rd_addr == `ADCDC_A_TALLY) rd_word = {snap_tally, 16'h0000};
    else if (rd_addr >= `ADCDC_A_CHAN0 && rd_addr <= `ADCDC_A_CHAN15)
      rd_word = {chan[4'(rd_addr - `ADCDC_A_CHAN0)], 8'h00};
    else if (rd_addr >= `ADCDC_A_OFF0 && rd_addr <= `ADCDC_A_OFF7)
      rd_word = off[3'(rd_addr - `ADCDC_A_OFF0)];
    else if (rd_addr >= `ADCDC_A_GAIN0 && rd_addr <= `ADCDC_A_GAIN7)
      rd_word = gain[3'(rd_addr - `ADCDC_A_GAIN0)];
  end

  // shift-in and counters
  always_comb begin
    next_bit_cnt = (bit_cnt == `ADCDC_CNT_MAX) ? bit_cnt : 6'(bit_cnt + 6'h01);
    next_rx = {rx[30:0], mosi_i};
    next_cmd = (bit_cnt == `ADCDC_CMD_LAST) ? next_rx[7:0] : cmd;
    next_frame_tog = (bit_cnt == 6'h00) ? !frame_tog : frame_tog;
    next_tx = (bit_cnt == `ADCDC_TX_LOAD) ? rd_word : {tx[22:0], 1'b0};
  end

  // counter ends with the frame: cs high clears it without an edge
  always_ff @(posedge sclk_i or posedge cs_n_i or posedge rst_i) begin
    if (cs_n_i || rst_i) bit_cnt <= 6'h00;
    else bit_cnt <= next_bit_cnt;
  end

  // frame record kept after cs rises for the clk side to read
  always_ff @(posedge sclk_i) begin
    rx <= next_rx;
    cmd <= next_cmd;
    frame_bits <= next_bit_cnt;
  end
  // frame marker starts from the same level as the clk side's copy
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) frame_tog <= 1'b0;
    else frame_tog <= next_frame_tog;
  end

  // read data goes out on the falling edge
  always_ff @(negedge sclk_i or posedge cs_n_i or posedge rst_i) begin
    if (cs_n_i || rst_i) tx <= 24'h00_0000;
    else tx <= next_tx;
  end
  assign miso_o = tx[23];

  // ************************************
  // crossings into clk domain
  // ************************************
  logic cs_s1, cs_s2, cs_s3, cs_lvl, cs_lvl_q, next_cs_lvl;
  logic tg_s1, tg_s2, tg_s3, tg_lvl, tg_seen, next_tg_lvl, next_tg_seen;
  logic frame_end; // cs rose, frame record is stable

  always_comb begin
    next_cs_lvl = (cs_s2 == cs_s3) ? cs_s3 : cs_lvl;
    next_tg_lvl = (tg_s2 == tg_s3) ? tg_s3 : tg_lvl;
    frame_end = cs_lvl && !cs_lvl_q;
    next_tg_seen = frame_end ? tg_lvl : tg_seen;
  end

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {cs_s1, cs_s2, cs_s3, cs_lvl, cs_lvl_q} <= 5'b11111;
      {tg_s1, tg_s2, tg_s3, tg_lvl, tg_seen} <= 5'b00000;
    end else begin
      cs_s1 <= cs_n_i;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      cs_lvl <= next_cs_lvl;
      cs_lvl_q <= cs_lvl;
      tg_s1 <= frame_tog;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
      tg_lvl <= next_tg_lvl;
      tg_seen <= next_tg_seen;
    end
  end

  // ************************************
  // frame decode and register bank
  // ************************************
  logic [5:0] f_addr;
  logic f_go, f_ok, f_rd, f_wr;
  logic [23:0] ev, clr, live_en;
  logic [2:0] cal_setup;

  always_comb begin
    f_addr = cmd[5:0];
    // a cs pulse with no clocks does not repeat the previous frame
    f_go = frame_end && (tg_lvl != tg_seen) && !cmd[`ADCDC_CMD_WEN];
    f_ok = frame_bits == frame_len(f_addr);
    f_rd = f_go && f_ok && cmd[`ADCDC_CMD_RD];
    f_wr = f_go && f_ok && !cmd[`ADCDC_CMD_RD];
    ev = fault_event_i; // analog side and map checksum sources
    ev[`ADCDC_FB_SCLK] = frame_end && (tg_lvl != tg_seen) && !f_ok;
    ev[`ADCDC_FB_READ] = f_rd && !readable(f_addr);
    ev[`ADCDC_FB_WRITE] = f_wr && !write_block_i && !writable(f_addr);
    ev[`ADCDC_FB_IGNORE] = f_wr && write_block_i;
    // clear only what the host actually saw in its read
    clr = (f_rd && f_addr == `ADCDC_A_FLAGS) ? snap_flags : 24'h00_0000;
    live_en = fen & `ADCDC_FB_IMPL;
    // set beats clear; disabled sources forced to zero
    next_flags = ((flags & ~clr) | ev) & live_en;
    next_err = |next_flags;
    next_ctrl = ctrl;
    next_fen = fen;
    next_chan = chan;
    next_off = off;
    next_gain = gain;
    if (f_wr && !write_block_i) begin
      if (f_addr == `ADCDC_A_CTRL) next_ctrl = rx[15:0];
      if (f_addr == `ADCDC_A_FEN) next_fen = rx[23:0];
      if (f_addr >= `ADCDC_A_CHAN0 && f_addr <= `ADCDC_A_CHAN15)
        next_chan[4'(f_addr - `ADCDC_A_CHAN0)] = rx[15:0];
      if (f_addr >= `ADCDC_A_OFF0 && f_addr <= `ADCDC_A_OFF7)
        next_off[3'(f_addr - `ADCDC_A_OFF0)] = rx[23:0];
      if (f_addr >= `ADCDC_A_GAIN0 && f_addr <= `ADCDC_A_GAIN7)
        next_gain[3'(f_addr - `ADCDC_A_GAIN0)] = rx[23:0];
    end
    // calibration result lands in the current channel's setup
    cal_setup = chan[cur][`ADCDC_CH_SETUP];
    if (cal_done_i) begin
      if (ctrl[`ADCDC_C_MODE] == `ADCDC_MODE_IOFF ||
          ctrl[`ADCDC_C_MODE] == `ADCDC_MODE_SOFF)
        next_off[cal_setup] = cal_coeff_i;
      if (ctrl[`ADCDC_C_MODE] == `ADCDC_MODE_IGAIN ||
          ctrl[`ADCDC_C_MODE] == `ADCDC_MODE_SGAIN)
        next_gain[cal_setup] = cal_coeff_i;
    end
    // tally counts master clock edges while enabled, wraps at 8 bits
    next_tally = fen[`ADCDC_EN_TALLY] ? 8'(tally + 8'h01) : tally;
  end

  // ************************************
  // sequencer and snapshots
  // ************************************
  logic [15:0] ch_en;

  always_comb begin
    for (int i = 0; i < N_CHAN; i++) ch_en[i] = chan[i][`ADCDC_CH_EN];
    next_cur = cur;
    // leave a channel the host just disabled
    if (!ch_en[cur] ||
        (conv_done_i && ctrl[`ADCDC_C_MODE] == `ADCDC_MODE_CONT))
      next_cur = seq_next(ch_en, cur);
    next_act = chan[cur];
    // snapshots only move between frames, so serial reads see a fixed word
    next_snap_flags = cs_lvl ? flags : snap_flags;
    next_snap_tally = cs_lvl ? tally : snap_tally;
    next_snap_status = snap_status;
    if (cs_lvl) begin
      next_snap_status = 8'h00;
      next_snap_status[`ADCDC_ST_ERR] = err;
      next_snap_status[3:0] = cur;
    end
  end

  // all bank state registered here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `ADCDC_CTRL_RST;
      fen <= `ADCDC_FEN_RST;
      flags <= `ADCDC_FLAGS_RST;
      tally <= `ADCDC_TALLY_RST;
      err <= 1'b0;
      for (int i = 0; i < N_CHAN; i++) chan[i] <= `ADCDC_CHANX_RST;
      chan[0] <= `ADCDC_CHAN0_RST;
      for (int i = 0; i < N_SETUP; i++) begin
        off[i] <= `ADCDC_OFF_RST;
        gain[i] <= `ADCDC_GAIN_RST;
      end
      cur <= 4'h0;
      act <= `ADCDC_CHAN0_RST;
      snap_flags <= `ADCDC_FLAGS_RST;
      snap_tally <= `ADCDC_TALLY_RST;
      snap_status <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
      fen <= next_fen;
      flags <= next_flags;
      tally <= next_tally;
      err <= next_err;
      chan <= next_chan;
      off <= next_off;
      gain <= next_gain;
      cur <= next_cur;
      act <= next_act;
      snap_flags <= next_snap_flags;
      snap_tally <= next_snap_tally;
      snap_status <= next_snap_status;
    end
  end

  // ************************************
  // outputs, all straight from flops
  // ************************************
  assign err_o = err;
  assign power_mode_o = ctrl[`ADCDC_C_POWER];
  assign op_mode_o = ctrl[`ADCDC_C_MODE];
  assign clk_sel_o = ctrl[`ADCDC_C_CLK];
  assign ref_en_o = ctrl[`ADCDC_C_REFEN];
  assign append_status_o = ctrl[`ADCDC_C_STATUS];
  assign continuous_readback_o = ctrl[`ADCDC_C_CREAD];
  assign output_ready_delay_o = ctrl[`ADCDC_C_DELAY];
  assign active_channel_o = cur;
  assign active_setup_o = act[`ADCDC_CH_SETUP];
  assign active_ainp_o = act[`ADCDC_CH_AINP];
  assign active_ainm_o = act[`ADCDC_CH_AINM];
endmodule // adcdc_regs

// ### tb/adcdc_regs_assertions.sv
// Purpose: port level checks of the diagnostic/control bank
// Assumes: one clk_i domain, rst_i synchronous active high
// Notes: bound to adcdc_regs from the bench top file
`timescale 1ns/100ps
`include "adcdc_defs.svh"
module adcdc_regs_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic write_block_i,
  input wire logic conv_done_i,
  input wire logic cal_done_i,
  input wire logic [23:0] cal_coeff_i,
  input wire logic [23:0] fault_event_i,
  input wire logic miso_o,
  input wire logic err_o,
  input wire logic [1:0] power_mode_o,
  input wire logic [3:0] op_mode_o,
  input wire logic [1:0] clk_sel_o,
  input wire logic ref_en_o,
  input wire logic append_status_o,
  input wire logic continuous_readback_o,
  input wire logic output_ready_delay_o,
  input wire logic [3:0] active_channel_o,
  input wire logic [2:0] active_setup_o,
  input wire logic [4:0] active_ainp_o,
  input wire logic [4:0] active_ainm_o
);
  // ****
  // clocking
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****
  // properties
  // ****
  // outputs show reset values on the first edge after release
  property p_reset_vals;
    $fell(rst_i) |-> !err_o && op_mode_o == 4'h0 && power_mode_o == 2'h0
      && clk_sel_o == 2'h0 && active_channel_o == 4'h0;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("reset value wrong");
  // control only moves once a frame has closed
  property p_ctrl_framed;
    $changed({power_mode_o, op_mode_o, clk_sel_o, ref_en_o, append_status_o,
      continuous_readback_o, output_ready_delay_o})
      |-> cs_n_i && $past(cs_n_i, 3);
  endproperty
  a_ctrl_framed: assert property (p_ctrl_framed)
    else $error("control moved inside a frame");
  // summary error needs an event or a closed frame
  property p_err_cause;
    $rose(err_o) |-> $past(|fault_event_i) || cs_n_i;
  endproperty
  a_err_cause: assert property (p_err_cause)
    else $error("error rose without cause");
  // flags only clear through a frame (read or enable write)
  property p_err_clear;
    $fell(err_o) |-> cs_n_i;
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("error fell inside a frame");
  property p_seq_cause;
    $changed(active_channel_o) |-> $past(conv_done_i) || cs_n_i;
  endproperty
  a_seq_cause: assert property (p_seq_cause)
    else $error("channel moved without cause");
  // no stepping on conversion done outside continuous mode
  property p_seq_hold;
    conv_done_i && op_mode_o != `ADCDC_MODE_CONT |=> $stable(active_channel_o);
  endproperty
  a_seq_hold: assert property (p_seq_hold)
    else $error("channel stepped outside continuous mode");
  // channel fields follow one clock later
  property p_fields;
    $changed(active_channel_o)
      |=> $changed({active_setup_o, active_ainp_o, active_ainm_o});
  endproperty
  a_fields: assert property (p_fields)
    else $error("channel fields did not follow");
  property p_miso_idle;
    cs_n_i && $past(cs_n_i) |-> !miso_o;
  endproperty
  a_miso_idle: assert property (p_miso_idle)
    else $error("serial out not idle");
  c_err: cover property ($rose(err_o));
  c_step: cover property ($changed(active_channel_o));
  c_mode: cover property ($changed(op_mode_o));
endmodule // adcdc_regs_assertions

// ### tb/adcdc_host.sv
// Purpose: host controller model driving serial frames
// Assumes: mode 3, msb first, 64 ns serial clock
// Notes: serial clock stands high between frames
`timescale 1ns/100ps
module adcdc_host (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i,
  output logic [23:0] rdata_o,
  output logic done_o
);
  // ****
  // idle state
  // ****
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
    rdata_o = 24'h00_0000;
    done_o = 1'b0;
  end
  // one frame of n bits; rd toggles done_o with the data
  task automatic xfer(input int n, input logic [31:0] tx, input logic rd);
    logic [31:0] rx;
    rx = 32'h0000_0000;
    cs_n_o = 1'b0;
    #13;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o = 1'b0;
      mosi_o = tx[i];
      #32;
      sclk_o = 1'b1;
      rx = {rx[30:0], miso_i};
      #32;
    end
    // released line must not keep the last bit
    mosi_o = ~mosi_o;
    cs_n_o = 1'b1;
    if (rd) begin
      rdata_o = rx[23:0] & ~(24'hFF_FFFF << (n - 8));
      done_o = ~done_o;
    end
    // long gap so a write has landed before the next frame
    #100;
  endtask
endmodule // adcdc_host

// ### tb/adcdc_regs_bench.sv
// Purpose: self-checking bench of the diagnostic/control bank
// Assumes: host model drives the serial side
// Notes: reads are scored from a queue of expected words
`timescale 1ns/100ps
`include "adcdc_defs.svh"
module adc_diagnostic_and_control_regs_bench;
  logic clk_i, rst_i, write_block_i, conv_done_i, cal_done_i;
  logic sclk, cs_n, mosi, miso, err_o, ref_en_o, append_status_o;
  logic continuous_readback_o, output_ready_delay_o, h_done;
  logic [23:0] cal_coeff_i, fault_event_i, h_data, ev;
  logic [1:0] power_mode_o, clk_sel_o;
  logic [3:0] op_mode_o, active_channel_o;
  logic [2:0] active_setup_o;
  logic [4:0] active_ainp_o, active_ainm_o;
  logic [15:0] v;
  int fail_count = 0;
  int tests_run = 0;
  adcdc_pkg::adcdc_word_t exp_q[$]; // expected read words
  adcdc_regs uut (.clk_i, .rst_i, .sclk_i(sclk), .cs_n_i(cs_n),
    .mosi_i(mosi), .write_block_i, .conv_done_i, .cal_done_i, .cal_coeff_i,
    .fault_event_i, .miso_o(miso), .err_o, .power_mode_o, .op_mode_o,
    .clk_sel_o, .ref_en_o, .append_status_o, .continuous_readback_o,
    .output_ready_delay_o, .active_channel_o, .active_setup_o,
    .active_ainp_o, .active_ainm_o);
  adcdc_host host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
    .miso_i(miso), .rdata_o(h_data), .done_o(h_done));
  // ****
  // tasks
  // ****
  task automatic check(input adcdc_pkg::adcdc_word_t s,
    input adcdc_pkg::adcdc_word_t e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic conclude();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input adcdc_pkg::adcdc_addr_t a, input int nb,
    input adcdc_pkg::adcdc_word_t d);
    host.xfer(8 + 8 * nb, ({2'b00, a, 24'h0} >> (24 - 8 * nb)) | 32'(d), 0);
  endtask
  task automatic rd(input adcdc_pkg::adcdc_addr_t a, input int nb,
    input adcdc_pkg::adcdc_word_t e);
    exp_q.push_back(e);
    host.xfer(8 + 8 * nb, {2'b01, a, 24'h0} >> (24 - 8 * nb), 1'b1);
  endtask
  // k: 0 fault event, 1 conversion done, 2 calibration done
  task automatic strobe(input int k, input adcdc_pkg::adcdc_word_t d);
    @(posedge clk_i);
    if (k == 0) fault_event_i <= d;
    if (k == 1) conv_done_i <= 1'b1;
    if (k == 2) begin
      cal_coeff_i <= d;
      cal_done_i <= 1'b1;
    end
    @(posedge clk_i);
    fault_event_i <= 24'h00_0000;
    conv_done_i <= 1'b0;
    cal_done_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  // ****
  // clock, monitor, watchdog
  // ****
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial forever begin
    @(h_done);
    if (exp_q.size() > 0) check(h_data, exp_q.pop_front());
  end
  initial begin
    #200000;
    fail_count++;
    conclude();
  end
  // ****
  // scenarios
  // ****
  initial begin
    {rst_i, write_block_i, conv_done_i, cal_done_i} = 4'h0;
    cal_coeff_i = 24'h00_0000;
    fault_event_i = 24'h00_0000;
    void'($urandom(32'h1fa7));
    do_reset();
    rd(`ADCDC_A_FEN, 3, `ADCDC_FEN_RST);
    rd(`ADCDC_A_FLAGS, 3, 24'h00_0000);
    rd(`ADCDC_A_TALLY, 1, 24'h00_0000);
    // write attempted while blocked is dropped and flagged
    @(posedge clk_i);
    write_block_i <= 1'b1;
    wr(`ADCDC_A_CTRL, 2, 24'h00_00C0);
    @(posedge clk_i);
    write_block_i <= 1'b0;
    check(power_mode_o, 2'h0);
    check(err_o, 1'b1);
    rd(`ADCDC_A_FLAGS, 3, 24'h00_0040);
    check(err_o, 1'b0);
    // unknown address is one byte long, so only the access flags fire; the 20-bit frame adds the clock count flag
    wr(`ADCDC_A_FEN, 3, 24'h00_0078);
    wr(6'h02, 1, 24'h00_0000);
    rd(6'h02, 1, 24'h00_0000);
    wr(`ADCDC_A_TALLY, 1, 24'h00_0055);
    host.xfer(20, {2'b00, `ADCDC_A_CTRL, 12'h0C5}, 1'b0);
    rd(`ADCDC_A_CTRL, 2, 24'h00_0000);
    rd(`ADCDC_A_FLAGS, 3, 24'h00_0038);
    // disabled source stays silent, enabled ones report
    wr(`ADCDC_A_FEN, 3, 24'h00_0040);
    strobe(0, 24'h00_0002);
    check(err_o, 1'b0);
    ev = (24'($urandom) & 24'h0F_FA87) | 24'h00_0002;
    wr(`ADCDC_A_FEN, 3, 24'h0F_FAFF);
    strobe(0, ev);
    check(err_o, 1'b1);
    rd(`ADCDC_A_FLAGS, 3, ev);
    wr(`ADCDC_A_FEN, 3, 24'h40_0040);
    host.xfer(16, {2'b01, `ADCDC_A_TALLY, 8'h00}, 1'b1);
    check(h_data != 24'h00_0000, 1'b1);
    // random control word, continuous readback left by reset
    v = 16'($urandom) & 16'h15FF;
    wr(`ADCDC_A_CTRL, 2, v);
    check(power_mode_o, v[7:6]);
    check(op_mode_o, v[5:2]);
    check({clk_sel_o, ref_en_o}, {v[1:0], v[8]});
    check({append_status_o, output_ready_delay_o}, {v[10], v[12]});
    rd(`ADCDC_A_CTRL, 2, v);
    wr(`ADCDC_A_CTRL, 2, 24'h00_0800);
    check(continuous_readback_o, 1'b1);
    do_reset();
    check(continuous_readback_o, 1'b0);
    // channels 2 and 5 enabled, channel 0 dropped
    wr(`ADCDC_A_CHAN0 + 6'd2, 2, 24'h00_B085);
    wr(`ADCDC_A_CHAN0 + 6'd5, 2, 24'h00_F043);
    wr(`ADCDC_A_CHAN0, 2, 24'h00_0001);
    check(active_channel_o, 4'h2);
    check({active_setup_o, active_ainp_o, active_ainm_o}, 13'h0C85);
    strobe(1, 24'h00_0000);
    check(active_channel_o, 4'h5);
    strobe(1, 24'h00_0000);
    check(active_channel_o, 4'h2);
    // status byte: no error, sequencer on channel 2
    rd(`ADCDC_A_STATUS, 1, 24'h00_0002);
    // calibration writes setup 3 of the current channel
    wr(`ADCDC_A_CTRL, 2, 24'h00_0014);
    ev = 24'($urandom);
    strobe(2, ev);
    rd(`ADCDC_A_OFF0 + 6'd3, 3, ev);
    wr(`ADCDC_A_CTRL, 2, 24'h00_0018);
    ev = 24'($urandom);
    strobe(2, ev);
    rd(`ADCDC_A_GAIN0 + 6'd3, 3, ev);
    strobe(1, 24'h00_0000);
    check(active_channel_o, 4'h2);
    conclude();
  end
endmodule // adc_diagnostic_and_control_regs_bench
bind adcdc_regs adcdc_regs_assertions chk (.clk_i, .rst_i, .sclk_i, .cs_n_i,
  .mosi_i, .write_block_i, .conv_done_i, .cal_done_i, .cal_coeff_i,
  .fault_event_i, .miso_o, .err_o, .power_mode_o, .op_mode_o, .clk_sel_o,
  .ref_en_o, .append_status_o, .continuous_readback_o, .output_ready_delay_o,
  .active_channel_o, .active_setup_o, .active_ainp_o, .active_ainm_o);
